// ==== core/fault_record.v ====
`timescale 1ns/10ps
`default_nettype none
`include "fault_record_regs.vh"
// Notes on behaviour
// - walk abort uses code 0x0b; stage-one abort clears stage bit, class table-walk.
// - nested stage-one abort after good intermediate translation reports like stage-one-only.
// - walk abort record carries a software-chosen cause code.
// - 32-bit descriptor fetch with output size below 40: upper fetch bits free.
// - merge comparison ignores input address bits 11 to 0.
// - first version writes zero to fetch address bits 51 to 48.
// - translation fault record has code 0x10 in word zero low byte.
// - translation fault on range failure, disabled table base, or no valid descriptor.
// - word three packs class, stage, security, direction, instruction, privilege bits.
// - instruction and privilege reported after stream table overrides.
// - a write access always reports instruction bit zero.
// - stage-one translation fault: stage bit clear, class input, intermediate field zero.
// - stage-two fault on context fetch: class context, context address reported.
// - stage-two fault during stage-one walk: class table-walk, descriptor address reported.
// - stage-two fault on transaction address: class input, intermediate address reported.
// - a record with stall set is never merged.
// - first version writes zero to intermediate address bits 51 to 48.
module fault_record (
   input  wire        clock,
   input  wire        srst,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output reg         pslverr,
   input  wire        fault_valid,
   output wire        fault_ready,
   input  wire        fault_walk_abort,
   input  wire        fault_stage_two,
   input  wire [1:0]  fault_context,
   input  wire        fault_range_fail,
   input  wire        fault_base_disabled,
   input  wire        fault_no_desc,
   input  wire        fault_desc_32bit,
   input  wire [19:0] sub_stream_id_a,
   input  wire        sub_stream_valid,
   input  wire [31:0] stream_id_b,
   input  wire        fault_stall,
   input  wire [15:0] fault_stall_tag,
   input  wire        nonsecure_flag,
   input  wire        read_not_write,
   input  wire        raw_instr,
   input  wire        raw_priv,
   input  wire        ovr_instr_en,
   input  wire        ovr_instr_val,
   input  wire        ovr_priv_en,
   input  wire        ovr_priv_val,
   input  wire [63:0] input_address,
   input  wire [51:0] fault_ipa,
   input  wire [51:0] descriptor_fetch_address,
   output wire        ev_valid,
   input  wire        ev_ready,
   output reg  [31:0] ev_word,
   output reg  [2:0]  ev_index,
   output wire        ev_last
);
   localparam ST_IDLE = 2'h0;
   localparam ST_FILL = 2'h1;
   localparam ST_READ = 2'h2;
   localparam ST_SEND = 2'h3;

   reg  [1:0]   state_reg;
   reg  [31:0]  ctrl_reg;
   reg  [5:0]   out_size_reg;
   reg  [15:0]  written_reg;
   reg  [15:0]  merged_reg;
   reg  [255:0] rec_reg;
   reg  [255:0] prev_key_reg;
   reg          prev_valid_reg;
   reg          prev_stall_reg;
   reg  [2:0]   idx_reg;
   reg  [2:0]   rd_idx_reg;
   reg          word_valid_reg;
   wire [31:0]  mem_rdata;

   wire enable      = ctrl_reg[0];
   wire merge_en    = ctrl_reg[1];
   wire first_ver   = ctrl_reg[2];
   wire [7:0]  walk_reason = ctrl_reg[15:8];
   wire [15:0] impl_upper  = ctrl_reg[31:16];

   // upper address word, top nibble forced to zero in the first version
   function [31:0] high_word;
      input [51:0] addr;
      input        v1;
      begin
         high_word = {12'h000, (v1 ? 4'h0 : addr[51:48]), addr[47:32]};
      end
   endfunction

   // clear fetch bits from the output size up to 47 after a truncated fetch
   function [51:0] trunc_fetch;
      input [51:0] addr;
      input [5:0]  size;
      input        trunc;
      integer      i;
      begin
         trunc_fetch = addr;
         for (i = 0; i < 48; i = i + 1) begin
            if (trunc && (i >= size)) begin
               trunc_fetch[i] = 1'b0;
            end
         end
      end
   endfunction

   // record assembly
   reg [255:0] rec_next;
   reg [1:0]   class_c;
   reg         stage2_c;
   reg [1:0]   cause_c;
   reg         instr_c;
   reg         priv_c;
   reg [51:0]  fetch_c;
   reg [51:0]  addr2_c;
   reg         trans_fault;

   always @* begin
      rec_next    = 256'h0;
      class_c     = `CLASS_IN;
      stage2_c    = 1'b0;
      cause_c     = 2'h0;
      addr2_c     = 52'h0;
      trans_fault = fault_range_fail | fault_base_disabled | fault_no_desc;
      if (fault_range_fail) begin
         cause_c = `CAUSE_RANGE;
      end else if (fault_base_disabled) begin
         cause_c = `CAUSE_BASE_DISABLED;
      end else if (fault_no_desc) begin
         cause_c = `CAUSE_NO_DESC;
      end
      priv_c  = ovr_priv_en ? ovr_priv_val : raw_priv;
      instr_c = (ovr_instr_en ? ovr_instr_val : raw_instr) & read_not_write;
      fetch_c = trunc_fetch(descriptor_fetch_address, out_size_reg,
                            fault_desc_32bit && (out_size_reg < `OUT_SIZE_LIMIT));
      if (fault_stage_two) begin
         stage2_c = 1'b1;
         case (fault_context)
            `CTX_DESC_FETCH: class_c = `CLASS_CTX;
            `CTX_TT_WALK:   class_c = `CLASS_TT;
            default:        class_c = `CLASS_IN;
         endcase
         addr2_c = fault_ipa;
      end else begin
         stage2_c = 1'b0;
         class_c = fault_walk_abort ? `CLASS_TT : `CLASS_IN;
         addr2_c = 52'h0;
      end
      if (fault_walk_abort) begin
         addr2_c = {fetch_c[51:3], 3'h0};
      end
      rec_next[7:0] = fault_walk_abort ? `EV_CODE_WALK_ABORT : `EV_CODE_TRANSLATION;
      rec_next[`W0_SUBV_BIT]              = sub_stream_valid;
      rec_next[`W0_SSID_LSB +: 20]        = sub_stream_id_a;
      rec_next[32 +: 32]                  = stream_id_b;
      rec_next[64 + `W2_STALL_BIT]        = fault_stall;
      rec_next[64 +: 16]                  = fault_stall_tag;
      rec_next[96 + `W3_PRIV_BIT]         = priv_c;
      rec_next[96 + `W3_INSTR_BIT]        = instr_c;
      rec_next[96 + `W3_DIR_BIT]          = read_not_write;
      rec_next[96 + `W3_NONSEC_BIT]       = nonsecure_flag;
      rec_next[96 + `W3_STAGE_BIT]        = stage2_c;
      rec_next[96 + `W3_CLASS_LSB +: 2]   = class_c;
      if (fault_walk_abort) begin
         rec_next[96 + `W3_UPPER_LSB +: 16] = {8'h00, walk_reason};
      end else begin
         rec_next[96 + `W3_CAUSE_LSB +: 2]  = cause_c;
         rec_next[96 + `W3_UPPER_LSB +: 16] = impl_upper;
      end
      rec_next[128 +: 64] = input_address;
      if (fault_walk_abort) begin
         rec_next[192 +: 32] = {addr2_c[31:3], 3'h0};
      end else begin
         rec_next[192 +: 32] = {addr2_c[31:12], 12'h000};
      end
      rec_next[224 +: 32] = high_word(addr2_c, first_ver);
   end

   // merge key drops the page offset of the input address
   wire [255:0] key_next = {rec_next[255:140], 12'h000, rec_next[127:0]};
   wire merge_hit = merge_en && prev_valid_reg && !fault_stall && !prev_stall_reg &&
                    (key_next == prev_key_reg);
   wire accept = (state_reg == ST_IDLE) && fault_valid && enable;
   wire take   = accept && (fault_walk_abort || trans_fault);

   assign fault_ready = (state_reg == ST_IDLE) && enable;
   assign ev_valid    = (state_reg == ST_SEND) && word_valid_reg;
   assign ev_last     = ev_valid && (ev_index == 3'h7);

   record_mem #(
      .DEPTH (`REC_WORDS),
      .AW    (3)
   ) u_mem (
      .clock   (clock),
      .wr_en   (state_reg == ST_FILL),
      .wr_addr (idx_reg),
      .wr_data (rec_reg[{idx_reg, 5'h00} +: 32]),
      .rd_addr (rd_idx_reg),
      .rd_data (mem_rdata)
   );

   always @(posedge clock) begin
      if (srst) begin
         state_reg      <= ST_IDLE;
         rec_reg        <= 256'h0;
         prev_key_reg   <= 256'h0;
         prev_valid_reg <= 1'b0;
         prev_stall_reg <= 1'b0;
         idx_reg        <= 3'h0;
         rd_idx_reg     <= 3'h0;
         word_valid_reg <= 1'b0;
         ev_word        <= 32'h0;
         ev_index       <= 3'h0;
         written_reg    <= 16'h0;
         merged_reg     <= 16'h0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (take) begin
                  if (merge_hit) begin
                     merged_reg <= merged_reg + 16'h0001;
                  end else begin
                     rec_reg        <= rec_next;
                     prev_key_reg   <= key_next;
                     prev_valid_reg <= 1'b1;
                     prev_stall_reg <= fault_stall;
                     idx_reg        <= 3'h0;
                     state_reg      <= ST_FILL;
                  end
               end
            end
            ST_FILL: begin
               idx_reg <= idx_reg + 3'h1;
               if (idx_reg == 3'h7) begin
                  rd_idx_reg <= 3'h0;
                  state_reg  <= ST_READ;
               end
            end
            ST_READ: begin
               // memory read data arrive one cycle after the address
               word_valid_reg <= 1'b0;
               state_reg      <= ST_SEND;
            end
            ST_SEND: begin
               if (!word_valid_reg) begin
                  ev_word        <= mem_rdata;
                  ev_index       <= rd_idx_reg;
                  word_valid_reg <= 1'b1;
               end else if (ev_ready) begin
                  word_valid_reg <= 1'b0;
                  if (rd_idx_reg == 3'h7) begin
                     written_reg <= written_reg + 16'h0001;
                     state_reg   <= ST_IDLE;
                  end else begin
                     rd_idx_reg <= rd_idx_reg + 3'h1;
                     state_reg  <= ST_READ;
                  end
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // apb slave, zero wait states
   wire apb_write = psel && penable && pwrite;
   wire apb_read  = psel && penable && !pwrite;
   wire addr_ok   = (paddr == `REG_CTRL) || (paddr == `REG_CFG) ||
                    (paddr == `REG_STATUS) || (paddr == `REG_COUNT);

   assign pready = 1'b1;

   always @(posedge clock) begin
      if (srst) begin
         ctrl_reg <= `CTRL_RESET;
         out_size_reg <= `OUT_SIZE_RESET;
      end else if (apb_write) begin
         if (paddr == `REG_CTRL) begin
            ctrl_reg <= pwdata;
         end
         if (paddr == `REG_CFG) begin
            out_size_reg <= pwdata[5:0];
         end
      end
   end

   always @* begin
      prdata  = 32'h0;
      pslverr = (apb_read || apb_write) && !addr_ok;
      if (apb_read) begin
         case (paddr)
            `REG_CTRL:   prdata = ctrl_reg;
            `REG_CFG:    prdata = {26'h0, out_size_reg};
            `REG_STATUS: prdata = {29'h0, prev_valid_reg, fault_ready, state_reg != ST_IDLE};
            `REG_COUNT:  prdata = {merged_reg, written_reg};
            default:     prdata = 32'h0;
         endcase
      end
   end
endmodule
`default_nettype wire

// ==== core/fault_record_regs.vh ====
`ifndef FAULT_RECORD_REGS_VH
`define FAULT_RECORD_REGS_VH

// event codes
`define EV_CODE_WALK_ABORT     8'h0b
`define EV_CODE_TRANSLATION    8'h10

// fault class encodings
`define CLASS_CTX              2'h0
`define CLASS_TT               2'h1
`define CLASS_IN               2'h2

// walk context of the faulting access
`define CTX_DESC_FETCH         2'h0
`define CTX_TT_WALK            2'h1
`define CTX_TRANSACTION        2'h2

// translation fault cause codes
`define CAUSE_RANGE            2'h1
`define CAUSE_BASE_DISABLED    2'h2
`define CAUSE_NO_DESC          2'h3

// word 0 layout
`define W0_SUBV_BIT            11
`define W0_SSID_LSB            12
// word 2 layout
`define W2_STALL_BIT           31
// word 3 layout
`define W3_PRIV_BIT            0
`define W3_INSTR_BIT           1
`define W3_DIR_BIT             2
`define W3_NONSEC_BIT          3
`define W3_STAGE_BIT           7
`define W3_CLASS_LSB           8
`define W3_CAUSE_LSB           12
`define W3_UPPER_LSB           16

// register byte offsets
`define REG_CTRL               12'h000
`define REG_CFG                12'h004
`define REG_STATUS             12'h008
`define REG_COUNT              12'h00c

// reset values and output size truncation limit
`define CTRL_RESET             32'h0000_0003
`define OUT_SIZE_RESET         6'h30
`define OUT_SIZE_LIMIT         6'h28

// record shape
`define REC_WORDS              8
`endif

// ==== core/record_mem.v ====
`timescale 1ns/10ps
`default_nettype none
module record_mem #(
   parameter DEPTH = 8,
   parameter AW    = 3
) (
   input  wire          clock,
   input  wire          wr_en,
   input  wire [AW-1:0] wr_addr,
   input  wire [31:0]   wr_data,
   input  wire [AW-1:0] rd_addr,
   output reg  [31:0]   rd_data
);
   reg [31:0] mem [0:DEPTH-1];

   always @(posedge clock) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end
endmodule
`default_nettype wire

// ==== dv/fault_record_chk.sv ====
`timescale 1ns/10ps
`default_nettype none
module fault_record_chk (
   input wire logic        clock,
   input wire logic        srst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        fault_valid,
   input wire logic        fault_ready,
   input wire logic        fault_walk_abort,
   input wire logic        fault_stage_two,
   input wire logic [1:0]  fault_context,
   input wire logic        read_not_write,
   input wire logic        raw_instr,
   input wire logic        raw_priv,
   input wire logic        ovr_instr_en,
   input wire logic        ovr_instr_val,
   input wire logic        ovr_priv_en,
   input wire logic        ovr_priv_val,
   input wire logic [31:0] stream_id_b,
   input wire logic        ev_valid,
   input wire logic        ev_ready,
   input wire logic [31:0] ev_word,
   input wire logic [2:0]  ev_index,
   input wire logic        ev_last
);
   logic        wk, stg, ins, prv, v1;
   logic [1:0]  cx;
   logic [31:0] sid;
   // request fields held from the taking edge; one record is in flight at a time
   always @(posedge clock) begin
      if (srst) begin
         v1 <= 1'b0;
      end else if (psel && penable && pwrite && paddr == 12'h000) begin
         v1 <= pwdata[2];
      end
      if (fault_valid && fault_ready) begin
         wk <= fault_walk_abort;
         stg <= fault_stage_two;
         cx <= fault_context;
         sid <= stream_id_b;
         prv <= ovr_priv_en ? ovr_priv_val : raw_priv;
         ins <= read_not_write & (ovr_instr_en ? ovr_instr_val : raw_instr);
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);
   property p_code;
      ev_valid && ev_index == 3'h0 |-> ev_word[7:0] == (wk ? 8'h0b : 8'h10);
   endproperty
   a_code: assert property (p_code) else $error("wrong event code");
   property p_s1t;
      ev_valid && ev_index == 3'h3 && !wk && !stg |-> ev_word[9:7] == 3'h4;
   endproperty
   a_s1t: assert property (p_s1t) else $error("stage one fault class");
   property p_s1ipa;
      ev_valid && ev_index[2:1] == 2'h3 && !wk && !stg |-> ev_word == 32'h0;
   endproperty
   a_s1ipa: assert property (p_s1ipa) else $error("stage one ipa not zero");
   property p_s1abt;
      ev_valid && ev_index == 3'h3 && wk && !stg |-> ev_word[9:7] == 3'h2;
   endproperty
   a_s1abt: assert property (p_s1abt) else $error("stage one abort class");
   property p_stage2;
      ev_valid && ev_index == 3'h3 && stg |-> ev_word[7] && ev_word[9:8] == cx;
   endproperty
   a_stage2: assert property (p_stage2) else $error("stage two class");
   property p_attr;
      ev_valid && ev_index == 3'h3 |-> ev_word[1:0] == {ins, prv};
   endproperty
   a_attr: assert property (p_attr) else $error("access attributes");
   property p_v1;
      ev_valid && ev_index == 3'h7 && v1 |-> ev_word[19:16] == 4'h0;
   endproperty
   a_v1: assert property (p_v1) else $error("upper address bits set");
   property p_sid;
      ev_valid && ev_index == 3'h1 |-> ev_word == sid;
   endproperty
   a_sid: assert property (p_sid) else $error("stream id word");
   // next word needs a memory read and a latch cycle after the handshake
   property p_step;
      ev_valid && ev_ready && !ev_last |=> !ev_valid ##1 !ev_valid ##1
         (ev_valid && ev_index == $past(ev_index, 3) + 3'h1);
   endproperty
   a_step: assert property (p_step) else $error("word order");
   property p_last;
      ev_valid |-> ev_last == (ev_index == 3'h7);
   endproperty
   a_last: assert property (p_last) else $error("last word flag");
endmodule
bind fault_record fault_record_chk chk (.*);
`default_nettype wire

// ==== dv/event_sink.sv ====
`timescale 1ns/10ps
`default_nettype none
module event_sink (
   input  wire logic        clock,
   input  wire logic        srst,
   input  wire logic        ev_valid,
   input  wire logic [31:0] ev_word,
   output var  logic        ev_ready = 1'b0
);
   logic [31:0] q[$];
   // random back-pressure, like a queue writer competing for memory
   always @(posedge clock) begin
      if (srst) begin
         ev_ready <= 1'b0;
      end else begin
         if (ev_valid && ev_ready) q.push_back(ev_word);
         ev_ready <= ($urandom % 3) != 0;
      end
   end
endmodule
`default_nettype wire

// ==== dv/test_translation_fault_event_record.sv ====
`timescale 1ns/10ps
`default_nettype none
module test_translation_fault_event_record;
   logic        clock = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, fault_valid = 0;
   logic        fault_walk_abort = 0, fault_stage_two = 0, fault_range_fail = 0;
   logic        fault_base_disabled = 0, fault_no_desc = 0, fault_desc_32bit = 0;
   logic        sub_stream_valid = 0, fault_stall = 0, nonsecure_flag = 0, read_not_write = 0;
   logic        raw_instr = 0, raw_priv = 0, ovr_instr_en = 0, ovr_instr_val = 0;
   logic        ovr_priv_en = 0, ovr_priv_val = 0, pready, pslverr, fault_ready, err;
   logic        ev_valid, ev_ready, ev_last, have = 0;
   logic [1:0]  fault_context = 0;
   logic [2:0]  ev_index;
   logic [11:0] paddr = 0;
   logic [15:0] fault_stall_tag = 0;
   logic [19:0] sub_stream_id_a = 0;
   logic [31:0] pwdata = 0, stream_id_b = 0, prdata, ev_word, rd, ctrl = 32'h3, e[8], lst[8];
   logic [51:0] fault_ipa = 0, descriptor_fetch_address = 0;
   logic [63:0] input_address = 0;
   logic [31:0] xq[$];
   int          n_fail = 0, total_checks = 0, nrec = 0, nmrg = 0;
   fault_record uut (.*);
   event_sink snk (.*);
   always #2.5 clock = ~clock;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1;
      do @(posedge clock); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   function automatic void build();
      logic [1:0]  cl, cs;
      logic [19:0] hi;
      logic        s1t, wk;
      wk = fault_walk_abort;
      s1t = !wk && !fault_stage_two;
      cl = fault_stage_two ? fault_context : wk ? 2'h1 : 2'h2;
      cs = fault_range_fail ? 2'h1 : fault_base_disabled ? 2'h2 : {2{fault_no_desc}};
      hi = wk ? descriptor_fetch_address[51:32] : s1t ? 20'h0 : fault_ipa[51:32];
      if (ctrl[2]) hi[19:16] = 4'h0;
      e[0] = {sub_stream_id_a, sub_stream_valid, 3'h0, wk ? 8'h0b : 8'h10};
      e[1] = stream_id_b;
      e[2] = {fault_stall, 15'h0, fault_stall_tag};
      e[3] = {wk ? {8'h0, ctrl[15:8]} : ctrl[31:16], 2'h0, cs, 2'h0, cl, fault_stage_two,
              3'h0, nonsecure_flag, read_not_write,
              read_not_write & (ovr_instr_en ? ovr_instr_val : raw_instr),
              ovr_priv_en ? ovr_priv_val : raw_priv};
      e[4] = input_address[31:0];
      e[5] = input_address[63:32];
      e[6] = wk ? {descriptor_fetch_address[31:3], 3'h0} : s1t ? 32'h0 : {fault_ipa[31:12], 12'h0};
      e[7] = {12'h0, hi};
   endfunction
   task automatic rnd(input logic ms);
      logic wk;
      int   c;
      wk = ms | 1'($urandom);
      c = wk ? 0 : $urandom % 4;
      @(posedge clock);
      fault_walk_abort <= wk;
      fault_range_fail <= c == 1;
      fault_base_disabled <= c == 2;
      fault_no_desc <= c == 3;
      fault_context <= 2'($urandom % 3);
      {fault_stage_two, fault_desc_32bit, sub_stream_valid, nonsecure_flag, read_not_write,
       raw_instr, raw_priv, ovr_instr_en, ovr_instr_val, ovr_priv_en,
       ovr_priv_val} <= 11'($urandom);
      fault_stall <= !ms & 1'($urandom);
      sub_stream_id_a <= 20'($urandom);
      stream_id_b <= $urandom;
      fault_stall_tag <= 16'($urandom);
      input_address <= {$urandom, $urandom};
      fault_ipa <= 52'({$urandom, $urandom});
      descriptor_fetch_address <= 52'({$urandom, $urandom});
   endtask
   task automatic send();
      logic m;
      @(posedge clock);
      build();
      fault_valid <= 1;
      do @(posedge clock); while (fault_ready !== 1'b1);
      fault_valid <= 0;
      m = ctrl[1] && have && !e[2][31] && !lst[2][31] && e[4][31:12] == lst[4][31:12];
      for (int k = 0; k < 8; k++) if (k != 4 && e[k] !== lst[k]) m = 0;
      if (fault_walk_abort || fault_range_fail || fault_base_disabled || fault_no_desc) begin
         if (m) begin
            nmrg++;
         end else begin
            foreach (e[k]) xq.push_back(e[k]);
            lst = e;
            have = 1;
            nrec++;
         end
      end
      for (int t = 0; t < 400 && snk.q.size() < xq.size(); t++) @(posedge clock);
      chk(snk.q.size(), xq.size(), "record words");
      while (xq.size() && snk.q.size()) chk(snk.q.pop_front(), xq.pop_front(), "word");
   endtask
   task automatic report_and_stop();
      $display("checks %0d fails %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      #100000;
      n_fail++;
      $display("FAIL %0t watchdog", $time);
      report_and_stop();
   end
   initial begin
      void'($urandom(32'hce9b));
      repeat (12) @(posedge clock);
      srst <= 0;
      apb(0, 12'h000, 0);
      chk(rd, 32'h3, "ctrl reset");
      apb(0, 12'h004, 0);
      chk(rd, 32'h30, "size reset");
      apb(0, 12'h010, 0);
      chk({err, rd[30:0]}, 32'h8000_0000, "unmapped");
      $display("test registers done");
      for (int i = 0; i < 40; i++) begin
         if (i % 20 == 0) begin
            ctrl = ($urandom & 32'hffff_ff00) | (i < 20 ? 32'h1 : 32'h5);
            apb(1, 12'h000, ctrl);
         end
         rnd(0);
         send();
      end
      $display("test records done");
      ctrl = 32'h3;
      apb(1, 12'h000, ctrl);
      rnd(1);
      send();
      @(posedge clock);
      input_address[11:0] <= ~input_address[11:0];
      send();
      @(posedge clock);
      input_address[12] <= ~input_address[12];
      send();
      @(posedge clock);
      fault_stall <= 1;
      send();
      send();
      @(posedge clock);
      fault_stall <= 0;
      send();
      apb(1, 12'h00c, 32'hffff_ffff);
      apb(0, 12'h00c, 0);
      chk(rd, {nmrg[15:0], nrec[15:0]}, "counts");
      $display("test merge done");
      report_and_stop();
   end
endmodule
`default_nettype wire
